/* File: rsbc_map.vh */
// Register map and constants of the receive system bus configuration block
// Function
// - Bussed bit 1 with outputs enabled: three-state data outputs in unselected groups.
// - Bussed bit 0: repeat each time slot value across all bus groups.
// - Signaling inhibit 1 stops ABCD insertion on PCM; 0 follows per-channel control.
// - Data edge bit: outputs change on rising (0) or falling (1) bus clock.
// - Sync edge bit: drive syncs on chosen edge, sample inputs on opposite edge.
// - Bussed freeze bit 1 three-states freeze in unused groups; 0 repeats it.
// - Writing 1 to centering bit restores read pointer initial delay; 0 does nothing.
// - With sync pins as outputs, centering also shifts bus sync alignment.
// - Centering leaves the slip status indication unchanged.
// - Normal mode: two frames deep, one frame initial delay.
// - Short mode: two frames deep, 32-bit delay, reverts to normal after slip.
// - Elastic mode: 674 bits deep, 32-bit delay, recenters on every slip.
// - Bypass: zero depth, ignore sync inputs; data outputs follow line bits, timebase still runs on bus clock.
// - Three-bit field picks the bit of the slot aligned with sync pulses.
// - Bit offset joins time-slot offset into 10-bit frame sync position.
// - Frame offset extends it to 15-bit multiframe sync position.
// - Bus output enable 0 holds all receive bus outputs in high impedance.
// - Sync offset beyond the timebase range yields no sync pulses.
`ifndef RSBC_MAP_VH
`define RSBC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSBC_ADDR_CFG 9'h0d1
`define RSBC_ADDR_BITOFS 9'h0d2
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define RSBC_CFG_BUSSED 7
`define RSBC_CFG_SIG_INH 6
`define RSBC_CFG_DATA_NEG 5
`define RSBC_CFG_SYNC_NEG 4
`define RSBC_CFG_BUSSED_FREEZE_OUTPUT 3
`define RSBC_CFG_CENTER 2
`define RSBC_CFG_RST 8'h00
`define RSBC_BITOFS_RST 3'h0
// ----------------------------------------
// Slip buffer modes and sizes
// ----------------------------------------
`define RSBC_MODE_NORMAL 2'h0
`define RSBC_MODE_SHORT 2'h1
`define RSBC_MODE_ELASTIC 2'h2
`define RSBC_MODE_BYPASS 2'h3
`define RSBC_ELASTIC_DEPTH 12'h2a2
`define RSBC_SHORT_DELAY 12'h020
// ----------------------------------------
// Bus interface modes
// ----------------------------------------
`define RSBC_SBI_64A 4'h4
`define RSBC_SBI_64B 4'h5
`define RSBC_SBI_32 4'h6
`define RSBC_SBI_24F 4'h7
`define RSBC_SBI_24 4'h8
`endif

/* File: rsbc_top.v */
// Receive system bus configuration, slip buffer and sync timebase of one framer
`timescale 1ns/1ps
`include "rsbc_map.vh"
module rsbc_top #(
   parameter MF_FRAMES = 16
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [8:0] i_cpu_addr,
   input wire i_cpu_wr,
   input wire [7:0] i_cpu_wdata,
   output reg [7:0] o_cpu_rdata,
   input wire [3:0] i_bus_interface_mode,
   input wire i_bus_output_enable,
   input wire [6:0] i_ts_offset,
   input wire [4:0] i_frame_offset,
   input wire i_fsync_is_output,
   input wire i_receive_bus_clock_in,
   input wire i_line_bit_en,
   input wire i_line_data,
   input wire i_sig_insert_en,
   input wire i_sig_bit,
   input wire i_ind_bit,
   input wire i_freeze_bit,
   output reg o_receive_pcm_out,
   output wire o_receive_pcm_oe,
   output reg o_receive_signaling_out,
   output wire o_receive_signaling_oe,
   output reg o_receive_indication_out,
   output wire o_receive_indication_oe,
   output reg o_signaling_freeze_out,
   output wire o_signaling_freeze_oe,
   input wire i_receive_frame_sync,
   output reg o_receive_frame_sync,
   output wire o_receive_frame_sync_oe,
   input wire i_receive_multiframe_sync,
   output reg o_receive_multiframe_sync,
   output wire o_receive_multiframe_sync_oe,
   output reg o_slip_pulse
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [10:0] frame_bits;
      input [3:0] mode;
      begin
         case (mode)
            `RSBC_SBI_64A, `RSBC_SBI_64B: frame_bits = 11'd512;
            `RSBC_SBI_32: frame_bits = 11'd256;
            `RSBC_SBI_24F: frame_bits = 11'd193;
            `RSBC_SBI_24: frame_bits = 11'd192;
            default: frame_bits = 11'd1024;
         endcase
      end
   endfunction

   function [11:0] inc_wrap;
      input [11:0] p;
      input [11:0] lim;
      begin
         inc_wrap = (p + 12'd1 >= lim) ? 12'd0 : p + 12'd1;
      end
   endfunction

   function [11:0] sub_wrap;
      input [11:0] a;
      input [11:0] b;
      input [11:0] lim;
      begin
         sub_wrap = (a >= b) ? a - b : a + lim - b;
      end
   endfunction

   // ----------------------------------------
   // Registers at the processor port
   // ----------------------------------------
   reg [7:0] cfg_q;
   reg [2:0] bit_ofs_q;
   reg center_q;
   reg short_reverted_q;
   wire wr_cfg = i_cpu_wr && (i_cpu_addr == `RSBC_ADDR_CFG);
   wire wr_ofs = i_cpu_wr && (i_cpu_addr == `RSBC_ADDR_BITOFS);
   wire [1:0] slip_mode = cfg_q[1:0];
   wire bypass = (slip_mode == `RSBC_MODE_BYPASS);

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cfg_q <= `RSBC_CFG_RST;
         bit_ofs_q <= `RSBC_BITOFS_RST;
         center_q <= 1'b0;
      end else begin
         center_q <= wr_cfg && i_cpu_wdata[`RSBC_CFG_CENTER];
         if (wr_cfg) begin
            cfg_q <= {i_cpu_wdata[7:3], 1'b0, i_cpu_wdata[1:0]};
         end
         if (wr_ofs) begin
            bit_ofs_q <= i_cpu_wdata[2:0];
         end
      end
   end

   always @* begin
      case (i_cpu_addr)
         `RSBC_ADDR_CFG: o_cpu_rdata = cfg_q;
         `RSBC_ADDR_BITOFS: o_cpu_rdata = {5'h00, bit_ofs_q};
         default: o_cpu_rdata = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Bus clock and sync pin sampling
   // ----------------------------------------
   reg [2:0] bclk_s;
   reg [2:0] fs_s;
   reg [2:0] ms_s;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         bclk_s <= 3'h0;
         fs_s <= 3'h0;
         ms_s <= 3'h0;
      end else begin
         bclk_s <= {bclk_s[1:0], i_receive_bus_clock_in};
         fs_s <= {fs_s[1:0], i_receive_frame_sync};
         ms_s <= {ms_s[1:0], i_receive_multiframe_sync};
      end
   end
   wire bclk_rise = bclk_s[1] && !bclk_s[2];
   wire bclk_fall = !bclk_s[1] && bclk_s[2];
   wire data_edge = cfg_q[`RSBC_CFG_DATA_NEG] ? bclk_fall : bclk_rise;
   wire sync_drv_edge = cfg_q[`RSBC_CFG_SYNC_NEG] ? bclk_fall : bclk_rise;
   wire sync_smp_edge = cfg_q[`RSBC_CFG_SYNC_NEG] ? bclk_rise : bclk_fall;
   wire fs_in_pulse = !bypass && !i_fsync_is_output && sync_smp_edge && fs_s[2];
   wire ms_in_pulse = !bypass && !i_fsync_is_output && sync_smp_edge && ms_s[2];

   // ----------------------------------------
   // Bus timebase and sync positions
   // ----------------------------------------
   wire [10:0] fbits = frame_bits(i_bus_interface_mode);
   wire [9:0] fs_pos = {i_ts_offset, bit_ofs_q};
   wire [14:0] ms_pos = {i_frame_offset, fs_pos};
   wire fs_in_range = ({1'b0, fs_pos} < fbits) && (i_frame_offset < MF_FRAMES);
   reg [9:0] bit_cnt_q;
   reg [4:0] frm_cnt_q;
   wire last_bit = ({1'b0, bit_cnt_q} + 11'd1 >= fbits);
   wire last_frm = ({27'h0, frm_cnt_q} + 32'd1 >= MF_FRAMES);
   wire center_realign = center_q && i_fsync_is_output;

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         bit_cnt_q <= 10'h000;
         frm_cnt_q <= 5'h00;
      end else if (center_realign) begin
         bit_cnt_q <= 10'h000;
         frm_cnt_q <= 5'h00;
      end else if (ms_in_pulse && fs_in_range) begin
         bit_cnt_q <= fs_pos;
         frm_cnt_q <= i_frame_offset;
      end else if (fs_in_pulse && fs_in_range) begin
         bit_cnt_q <= fs_pos;
      end else if (data_edge) begin
         bit_cnt_q <= last_bit ? 10'h000 : bit_cnt_q + 10'd1;
         if (last_bit) begin
            frm_cnt_q <= last_frm ? 5'h00 : frm_cnt_q + 5'd1;
         end
      end
   end

   // Sync outputs fire only at the programmed position inside the range
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_receive_frame_sync <= 1'b0;
         o_receive_multiframe_sync <= 1'b0;
      end else if (sync_drv_edge) begin
         o_receive_frame_sync <= fs_in_range && (bit_cnt_q == fs_pos);
         o_receive_multiframe_sync <= fs_in_range && ({frm_cnt_q, bit_cnt_q} == ms_pos);
      end
   end
   assign o_receive_frame_sync_oe = i_fsync_is_output && i_bus_output_enable;
   assign o_receive_multiframe_sync_oe = i_fsync_is_output && i_bus_output_enable;

   // ----------------------------------------
   // Bus group selection and output enables
   // ----------------------------------------
   reg grp_sel;
   always @* begin
      case (i_bus_interface_mode)
         4'h0, 4'h1, 4'h2, 4'h3: grp_sel = (bit_cnt_q[4:3] == i_bus_interface_mode[1:0]);
         `RSBC_SBI_64A, `RSBC_SBI_64B: grp_sel = (bit_cnt_q[3] == i_bus_interface_mode[0]);
         default: grp_sel = 1'b1;
      endcase
   end
   reg data_oe_q;
   reg frz_oe_q;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         data_oe_q <= 1'b0;
         frz_oe_q <= 1'b0;
      end else if (data_edge || !i_bus_output_enable) begin
         data_oe_q <= i_bus_output_enable && (!cfg_q[`RSBC_CFG_BUSSED] || grp_sel);
         frz_oe_q <= i_bus_output_enable && (!cfg_q[`RSBC_CFG_BUSSED_FREEZE_OUTPUT] || grp_sel);
      end
   end
   assign o_receive_pcm_oe = data_oe_q && i_bus_output_enable;
   assign o_receive_signaling_oe = data_oe_q && i_bus_output_enable;
   assign o_receive_indication_oe = data_oe_q && i_bus_output_enable;
   assign o_signaling_freeze_oe = frz_oe_q && i_bus_output_enable;

   // ----------------------------------------
   // Receive slip buffer
   // ----------------------------------------
   reg mem [0:2047];
   reg [11:0] wr_ptr_q;
   reg [11:0] rd_ptr_q;
   reg [11:0] depth;
   reg [11:0] delay;
   // Two frames of the 128-slot modes need the twelfth bit
   wire [11:0] fbits_w = {1'b0, fbits};
   always @* begin
      case (slip_mode)
         `RSBC_MODE_NORMAL: begin
            depth = {fbits, 1'b0};
            delay = fbits_w;
         end
         `RSBC_MODE_SHORT: begin
            depth = {fbits, 1'b0};
            delay = short_reverted_q ? fbits_w : `RSBC_SHORT_DELAY;
         end
         `RSBC_MODE_ELASTIC: begin
            depth = `RSBC_ELASTIC_DEPTH;
            delay = `RSBC_SHORT_DELAY;
         end
         default: begin
            depth = 12'd1;
            delay = 12'd0;
         end
      endcase
   end
   wire [11:0] fill = sub_wrap(wr_ptr_q, rd_ptr_q, depth);
   wire rd_go = data_edge && !bypass;
   wire wr_go = i_line_bit_en && !bypass;
   wire underrun = rd_go && (fill == 12'd0);
   wire overrun = wr_go && (fill + 12'd1 >= depth);
   wire slip = underrun || overrun;
   // A slip in short mode already behaves as in normal mode
   wire recenter_slip = slip && (slip_mode == `RSBC_MODE_ELASTIC);
   wire [11:0] wr_next = wr_go ? inc_wrap(wr_ptr_q, depth) : wr_ptr_q;

   always @(posedge i_clk) begin
      if (wr_go) begin
         mem[wr_ptr_q[10:0]] <= i_line_data;
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_ptr_q <= 12'h000;
         rd_ptr_q <= 12'h000;
         short_reverted_q <= 1'b0;
         o_slip_pulse <= 1'b0;
      end else begin
         o_slip_pulse <= slip;
         wr_ptr_q <= (wr_ptr_q >= depth) ? 12'h000 : wr_next;
         if (slip && slip_mode == `RSBC_MODE_SHORT) begin
            short_reverted_q <= 1'b1;
         end else if (wr_cfg) begin
            short_reverted_q <= 1'b0;
         end
         if (center_q || recenter_slip) begin
            rd_ptr_q <= sub_wrap(wr_next, delay, depth);
         end else if (slip) begin
            rd_ptr_q <= sub_wrap(wr_next, fbits_w, depth);
         end else if (rd_go) begin
            rd_ptr_q <= inc_wrap(rd_ptr_q, depth);
         end
      end
   end

   // ----------------------------------------
   // Output data path
   // ----------------------------------------
   wire buf_bit = bypass ? i_line_data : mem[rd_ptr_q[10:0]];
   wire ins_sig = i_sig_insert_en && !cfg_q[`RSBC_CFG_SIG_INH];
   wire out_go = bypass ? i_line_bit_en : data_edge;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_receive_pcm_out <= 1'b0;
         o_receive_signaling_out <= 1'b0;
         o_receive_indication_out <= 1'b0;
         o_signaling_freeze_out <= 1'b0;
      end else if (out_go) begin
         o_receive_pcm_out <= ins_sig ? i_sig_bit : buf_bit;
         o_receive_signaling_out <= i_sig_bit;
         o_receive_indication_out <= i_ind_bit;
         o_signaling_freeze_out <= i_freeze_bit;
      end
   end
endmodule

/* File: rsbc_props.sv */
// Assertion checker of the receive system bus configuration block
`timescale 1ns/1ps
module rsbc_props (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [8:0] i_cpu_addr,
   input wire i_cpu_wr,
   input wire [7:0] i_cpu_wdata,
   input wire [7:0] o_cpu_rdata,
   input wire i_bus_output_enable,
   input wire i_fsync_is_output,
   input wire o_receive_pcm_oe,
   input wire o_signaling_freeze_oe,
   input wire o_receive_frame_sync,
   input wire o_receive_frame_sync_oe,
   input wire o_receive_multiframe_sync_oe,
   input wire o_slip_pulse
);
   reg [7:0] cfg_q;
   wire wr_cfg = i_cpu_wr && i_cpu_addr == 9'h0d1;
   // Shadow of the configuration register, bypass excluded where outputs are not timebase driven
   always @(posedge i_clk)
      if (i_sys_rst)
         cfg_q <= 8'h00;
      else if (wr_cfg)
         cfg_q <= i_cpu_wdata;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   AST_OE_OFF: assert property (!i_bus_output_enable |-> !o_receive_pcm_oe && !o_signaling_freeze_oe)
      else $error("bus output driven while disabled");
   AST_SYNC_OE: assert property (o_receive_frame_sync_oe == (i_fsync_is_output && i_bus_output_enable)
      && o_receive_multiframe_sync_oe == o_receive_frame_sync_oe) else $error("sync enable wrong");
   AST_CTR_RD: assert property (i_cpu_addr == 9'h0d1 |-> !o_cpu_rdata[2])
      else $error("centering bit reads back");
   AST_WR_CFG: assert property (wr_cfg ##1 i_cpu_addr == 9'h0d1 |-> o_cpu_rdata == ($past(i_cpu_wdata) & 8'hfb))
      else $error("config readback wrong");
   AST_RSV_RD: assert property (i_cpu_addr == 9'h0d2 |-> o_cpu_rdata[7:3] == 5'h00)
      else $error("reserved offset bits set");
   AST_WR_OFS: assert property (i_cpu_wr && i_cpu_addr == 9'h0d2 ##1 i_cpu_addr == 9'h0d2
      |-> o_cpu_rdata == ($past(i_cpu_wdata) & 8'h07)) else $error("offset readback wrong");
   AST_BUS_HOLD: assert property (!cfg_q[7] && cfg_q[1:0] != 2'h3 && o_receive_pcm_oe |=>
      o_receive_pcm_oe || !i_bus_output_enable) else $error("unbussed data output released");
   AST_FRZ_HOLD: assert property (!cfg_q[3] && cfg_q[1:0] != 2'h3 && o_signaling_freeze_oe |=>
      o_signaling_freeze_oe || !i_bus_output_enable) else $error("unbussed freeze output released");
   AST_RST_Q: assert property (disable iff (1'b0) i_sys_rst |=> !o_slip_pulse && !o_receive_pcm_oe
      && !o_receive_frame_sync) else $error("output active after reset");
   COV_CENTER: cover property (wr_cfg && i_cpu_wdata[2]);
   COV_FSYNC: cover property ($rose(o_receive_frame_sync));
   COV_SLIP: cover property (o_slip_pulse);
endmodule
bind rsbc_top rsbc_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cpu_addr(i_cpu_addr),
   .i_cpu_wr(i_cpu_wr), .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata),
   .i_bus_output_enable(i_bus_output_enable), .i_fsync_is_output(i_fsync_is_output),
   .o_receive_pcm_oe(o_receive_pcm_oe), .o_signaling_freeze_oe(o_signaling_freeze_oe),
   .o_receive_frame_sync(o_receive_frame_sync), .o_receive_frame_sync_oe(o_receive_frame_sync_oe),
   .o_receive_multiframe_sync_oe(o_receive_multiframe_sync_oe), .o_slip_pulse(o_slip_pulse));

/* File: rsbc_bp.sv */
// Backplane model: bus clock and sync pulses of a 512-bit frame, 16-frame multiframe
`timescale 1ns/1ps
module rsbc_bp (
   input wire i_drive,
   output reg o_bclk,
   output reg o_fsync,
   output reg o_msync
);
   reg [12:0] bit_q;
   initial begin
      o_bclk = 1'b0;
      o_fsync = 1'b0;
      o_msync = 1'b0;
      bit_q = 13'h0000;
      #13.7;
      forever #80 o_bclk = ~o_bclk;
   end
   // Launch on rising so the device samples on falling; toggle when the pin is not ours
   always @(posedge o_bclk) begin
      bit_q <= bit_q + 13'h0001;
      o_fsync <= i_drive ? (bit_q[8:0] == 9'h000) : ~o_fsync;
      o_msync <= i_drive ? (bit_q == 13'h0000) : ~o_msync;
   end
endmodule

/* File: tb_top.sv */
// Testbench of the receive system bus configuration block
`timescale 1ns/1ps
module tb_top;
   reg i_clk, i_sys_rst, i_cpu_wr, i_bus_output_enable, i_fsync_is_output, i_line_bit_en, rd_v;
   reg i_line_data, i_sig_insert_en, i_sig_bit, i_ind_bit, i_freeze_bit;
   reg [8:0] i_cpu_addr;
   reg [7:0] i_cpu_wdata;
   reg [6:0] i_ts_offset;
   reg [2:0] lcnt = 3'h0;
   reg [4:0] i_frame_offset = 5'h00;
   reg dv = 1'b0, dv_q = 1'b0;
   reg [1:0] dchk = 2'h0;
   reg [3:0] exd_q[$];
   wire [7:0] o_cpu_rdata;
   wire pcm_oe, frz_oe, fs_o, fs_oe, ms_o, ms_oe, slip, bclk, bp_fs, bp_ms;
   wire d_pcm, d_sig, d_ind, d_frz, sig_oe, ind_oe;
   integer seed = 32'hcccc934a;
   integer err_total = 0, comparisons = 0, t0, t, n;
   integer pos[3] = '{0, 3, 13};
   reg [6:0] tso[5] = '{7'h00, 7'h00, 7'h01, 7'h7f, 7'h00};
   reg [2:0] bo[5] = '{3'h0, 3'h3, 3'h5, 3'h0, 3'h0};
   reg [7:0] exp_q[$];
   rsbc_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr),
      .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata), .i_bus_interface_mode(4'h4),
      .i_bus_output_enable(i_bus_output_enable), .i_ts_offset(i_ts_offset), .i_frame_offset(i_frame_offset),
      .i_fsync_is_output(i_fsync_is_output), .i_receive_bus_clock_in(bclk), .i_line_bit_en(i_line_bit_en),
      .i_line_data(i_line_data), .i_sig_insert_en(i_sig_insert_en), .i_sig_bit(i_sig_bit),
      .i_ind_bit(i_ind_bit), .i_freeze_bit(i_freeze_bit), .o_receive_pcm_out(d_pcm), .o_receive_pcm_oe(pcm_oe),
      .o_receive_signaling_out(d_sig), .o_receive_signaling_oe(sig_oe), .o_receive_indication_out(d_ind),
      .o_receive_indication_oe(ind_oe), .o_signaling_freeze_out(d_frz), .o_signaling_freeze_oe(frz_oe),
      .i_receive_frame_sync(fs_oe ? fs_o : bp_fs), .o_receive_frame_sync(fs_o), .o_receive_frame_sync_oe(fs_oe),
      .i_receive_multiframe_sync(ms_oe ? ms_o : bp_ms), .o_receive_multiframe_sync(ms_o),
      .o_receive_multiframe_sync_oe(ms_oe), .o_slip_pulse(slip));
   rsbc_bp bp (.i_drive(!i_fsync_is_output), .o_bclk(bclk), .o_fsync(bp_fs), .o_msync(bp_ms));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task test_done;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input [8:0] a, input [7:0] d);
      @(posedge i_clk);
      #1;
      i_cpu_addr = a;
      i_cpu_wdata = d;
      i_cpu_wr = 1'b1;
      @(posedge i_clk);
      #1;
      i_cpu_wr = 1'b0;
   endtask
   task rd(input [8:0] a, input [7:0] e);
      @(posedge i_clk);
      #1;
      i_cpu_addr = a;
      exp_q.push_back(e);
      rd_v = 1'b1;
      @(posedge i_clk);
      #1;
      rd_v = 1'b0;
   endtask
   task watch(output integer zp, output integer zf);
      zp = 0;
      zf = 0;
      repeat (60) @(posedge i_clk);
      repeat (400) begin
         @(posedge i_clk);
         zp = zp + (pcm_oe === 1'b0);
         zf = zf + (frz_oe === 1'b0);
      end
      #1;
   endtask
   task pulses(input integer sel, input integer len, output integer c);
      c = 0;
      repeat (len) begin
         @(posedge i_clk);
         c = c + ((sel ? slip : fs_o | ms_o) === 1'b1);
      end
   endtask
   task wait_fs(output integer w);
      w = 0;
      while (fs_o !== 1'b1 && w < 12000) begin
         @(posedge i_clk);
         w = w + 1;
      end
      if (w >= 12000) begin
         err_total = err_total + 1;
         test_done;
      end
   endtask
   // Register reads are compared here, oldest note first
   always @(posedge i_clk)
      if (rd_v)
         check({8'h00, o_cpu_rdata}, {8'h00, exp_q.pop_front()});
   // Bypass data bits are compared the cycle after the design takes them
   always @(posedge i_clk) begin
      if (dv_q)
         check({9'h000, d_pcm, d_sig, d_ind, d_frz, pcm_oe, sig_oe, ind_oe}, {9'h000, exd_q.pop_front(), 3'h7});
      dv_q <= dv;
   end
   // Line bits arrive faster than the bus drains them
   always @(posedge i_clk) begin
      #1;
      lcnt = lcnt + 3'h1;
      i_line_bit_en = (lcnt == 3'h0);
      {i_line_data, i_sig_insert_en, i_sig_bit, i_ind_bit, i_freeze_bit} = $random(seed);
      dv = i_line_bit_en && dchk[0];
      if (dv)
         exd_q.push_back({(i_sig_insert_en && !dchk[1]) ? i_sig_bit : i_line_data, i_sig_bit, i_ind_bit, i_freeze_bit});
   end
   initial begin
      i_sys_rst = 1'b1;
      i_cpu_wr = 1'b0;
      i_cpu_addr = 9'h000;
      i_cpu_wdata = 8'h00;
      i_bus_output_enable = 1'b0;
      i_fsync_is_output = 1'b0;
      i_ts_offset = 7'h00;
      i_line_bit_en = 1'b0;
      {i_line_data, i_sig_insert_en, i_sig_bit, i_ind_bit, i_freeze_bit} = 5'h00;
      rd_v = 1'b0;
      repeat (12) @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      rd(9'h0d1, 8'h00);
      rd(9'h0d2, 8'h00);
      rd(9'h0d0, 8'h00);
      wr(9'h0d1, 8'hff);
      wr(9'h0d2, 8'h07);
      rd(9'h0d1, 8'hfb);
      rd(9'h0d2, 8'h07);
      i_bus_output_enable = 1'b1;
      for (n = 0; n < 2; n = n + 1) begin
         wr(9'h0d1, n ? 8'h08 : 8'h80);
         watch(t0, t);
         check(t0 != 0, n == 0);
         check(t != 0, n == 1);
      end
      i_bus_output_enable = 1'b0;
      watch(t0, t);
      check(t0, 400);
      check(t, 400);
      i_bus_output_enable = 1'b1;
      i_fsync_is_output = 1'b1;
      wr(9'h0d1, 8'h00);
      for (n = 0; n < 5; n = n + 1) begin
         repeat (40) @(posedge i_clk);
         #1;
         i_ts_offset = tso[n];
         i_frame_offset = (n == 4) ? 5'h10 : 5'h00;
         wr(9'h0d2, {5'h00, bo[n]});
         wr(9'h0d1, 8'h04);
         if (n >= 3) begin
            pulses(0, 11000, t);
            check(t, 0);
         end else begin
            wait_fs(t);
            check(ms_o, 1'b1);
            if (n == 0)
               t0 = t;
            t = t - t0 - pos[n] * 20;
            check(t >= -24 && t <= 24, 1);
         end
      end
      for (n = 0; n < 2; n = n + 1) begin
         wr(9'h0d1, n ? 8'h03 : 8'h02);
         wr(9'h0d1, n ? 8'h07 : 8'h06);
         pulses(1, 10000, t);
         check(t != 0, n == 0);
      end
      for (n = 0; n < 2; n = n + 1) begin
         wr(9'h0d1, n ? 8'h43 : 8'h03);
         dchk = {n[0], 1'b1};
         repeat (200) @(posedge i_clk);
         #1;
         dchk = 2'h0;
      end
      repeat (4) @(posedge i_clk);
      test_done;
   end
endmodule
